/* File: logic/acs_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer #(
	parameter int unsigned CLK_HZ = acs_pkg::CLK_HZ
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic start_i,
	input wire logic mode_i,
	input wire logic [acs_pkg::RATE_W-1:0] sample_rate_select_i,
	input wire logic mod_bit_i,
	input wire acs_pkg::acs_gc_cmd_t gc_cmd_i,
	output logic [acs_pkg::CODE_W-1:0] result_o,
	output logic result_valid_o,
	output logic busy_o,
	output logic power_down_o
);
	import acs_pkg::*;

	typedef struct packed {
		acs_fsm_t fsm;
		logic [RATE_W-1:0] rate;
		logic [CNT_W-1:0] cnt;
		logic [DIV_W-1:0] div;
		logic mod_en;
		acs_result_t res;
		logic busy;
		logic pd;
	} acs_top_state_t;

	localparam acs_top_state_t TOP_RESET = '{
		fsm: ST_PWRDN, rate: RATE_RESET, cnt: '0, div: '0,
		mod_en: 1'b0, res: '0, busy: 1'b0, pd: 1'b1};
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CLK_HZ / MOD_HZ - 1);

	// Long counts follow CLK_HZ, so a lower CLK_HZ shortens simulation
	function automatic logic [CNT_W-1:0] conv_last(
		input logic [RATE_W-1:0] sel);
		conv_last = CNT_W'(CLK_HZ / rate_sps(sel) - 1);
	endfunction

	acs_top_state_t s;
	acs_top_state_t next_s;
	acs_result_t filt;
	logic done;
	logic start;
	logic gc_hit;

	always_comb
	begin
		next_s = s;
		next_s.mod_en = 1'b0;
		next_s.res.valid = 1'b0;
		done = 1'b0;
		start = 1'b0;
		gc_hit = gc_cmd_i.valid && (gc_cmd_i.code == GC_RESET_CODE);
		if (s.div == DIV_LAST)
		begin
			next_s.div = '0;
			next_s.mod_en = 1'b1;
		end
		else
		begin
			next_s.div = s.div + 16'h0001;
		end
		case (s.fsm)
			ST_PWRDN:
			begin
				if (start_i)
					start = 1'b1;
			end
			ST_CONV:
			begin
				if (s.cnt == conv_last(s.rate))
				begin
					done = 1'b1;
					if (mode_i)
						start = 1'b1;
					else
						next_s.fsm = ST_PWRDN;
				end
				else
				begin
					next_s.cnt = s.cnt + 24'h00_0001;
				end
			end
			default:
				next_s.fsm = ST_PWRDN;
		endcase
		if (start)
		begin
			// Rate is latched per conversion so a change cannot cut one short
			next_s.fsm = ST_CONV;
			next_s.rate = sample_rate_select_i;
			next_s.cnt = '0;
		end
		if (filt.valid)
			next_s.res = filt;
		next_s.busy = (next_s.fsm == ST_CONV);
		next_s.pd = (next_s.fsm == ST_PWRDN);
		if (gc_hit)
			next_s = TOP_RESET;
	end

	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			s <= TOP_RESET;
		else
			s <= next_s;
	end

	acs_decim u_decim (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.clear_i(start | gc_hit),
		.done_i(done & ~gc_hit),
		.sample_en_i(s.mod_en && (s.fsm == ST_CONV)),
		.mod_bit_i(mod_bit_i),
		.result_o(filt)
	);

	// Result only moves whole, in one edge, so a read never sees a mix
	assign result_o = s.res.code;
	assign result_valid_o = s.res.valid;
	assign busy_o = s.busy;
	assign power_down_o = s.pd;

	// Cycles since the running conversion began; kept apart from s.cnt so
	// the length checks below do not lean on the counter they guard
	logic [CNT_W-1:0] gap;

	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			gap <= '0;
		else if ((power_down_o && start_i) || done)
			gap <= '0;
		else
			gap <= gap + 24'h00_0001;
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	sequence seq_req;
		power_down_o && start_i && !gc_hit;
	endsequence
	sequence seq_done_single;
		done && !mode_i && !gc_hit;
	endsequence
	sequence seq_done_cont;
		done && mode_i && !gc_hit;
	endsequence

	// A general-call reset may land in any cycle, so later steps yield to it
	AST_REQ_STARTS: assert property (
		seq_req |=> (busy_o and (!gc_hit |=> busy_o)))
		else $error("request did not start a conversion");
	AST_REFUSED_BUSY: assert property (
		busy_o && !done && !gc_hit |=> busy_o && $stable(s.rate))
		else $error("request during a conversion disturbed it");
	AST_RESULT_UPDATE: assert property (
		filt.valid && !gc_hit |=>
		result_valid_o && result_o == $past(filt.code))
		else $error("result not stored");
	AST_SINGLE_STOPS: assert property (
		seq_done_single |=> ((power_down_o && !busy_o) and
		(!gc_hit |=> result_valid_o)))
		else $error("single conversion did not power down");
	AST_CONT_RESTART: assert property (
		seq_done_cont |=> busy_o && s.cnt == 24'h00_0000)
		else $error("continuous conversion did not restart");
	// Loose floor only; the exact spacing is held by the length checks
	AST_RATE_SPACING: assert property (
		done |=> !done [*8])
		else $error("conversions too close together");
	AST_CONT_RATE: assert property (
		seq_done_cont |=> s.rate == $past(sample_rate_select_i))
		else $error("continuous rate not taken from the select");
	AST_RESULT_HOLD: assert property (
		!filt.valid && !gc_hit |=> $stable(result_o))
		else $error("result changed without a conversion");
	// The average never passes full scale, so the lowest code stays unused
	AST_CODE_RANGE: assert property (
		result_valid_o |-> $signed(result_o) >= -12'sd2047)
		else $error("code out of range");
	AST_DECIM_OUT: assert property (
		done && !gc_hit |=> filt.valid)
		else $error("filter gave no code");
	AST_PWRDN_IDLE: assert property (
		power_down_o && !start_i |=> power_down_o && !busy_o)
		else $error("conversion without request");
	AST_GC_RESET: assert property (
		gc_hit |=> power_down_o && result_o == 12'h000 ##1 !result_valid_o)
		else $error("general call reset ignored");
	AST_RATE_LATCH: assert property (
		seq_req |=> s.rate == $past(sample_rate_select_i))
		else $error("rate select not latched at the start");
	// Each conversion is timed from its own start, first or continued
	// A rate change on the pins only counts from the next start
	AST_CONV_LEN: assert property (
		done |-> gap == conv_last(s.rate) && busy_o)
		else $error("conversion length wrong");
	AST_NO_OVERRUN: assert property (
		busy_o |-> gap <= conv_last(s.rate))
		else $error("conversion ran past its length");
endmodule
`default_nettype wire

/* File: logic/acs_pkg.sv */
package acs_pkg;
	localparam int unsigned CLK_HZ = 125_000_000;
	localparam int unsigned MOD_HZ = 250_000;
	localparam int unsigned MOD_DIV = CLK_HZ / MOD_HZ;
	localparam int CODE_W = 12;
	localparam int RATE_W = 3;
	localparam int CNT_W = 24;
	localparam int DIV_W = 16;
	localparam int ACC_W = 16;
	localparam int FULL_SCALE = 2047;
	localparam logic [7:0] GC_RESET_CODE = 8'h06;
	localparam logic [RATE_W-1:0] RATE_RESET = 3'h0;

	typedef enum logic [0:0] {
		ST_PWRDN = 1'b0,
		ST_CONV = 1'b1
	} acs_fsm_t;

	typedef struct packed {
		logic valid;
		logic [7:0] code;
	} acs_gc_cmd_t;

	typedef struct packed {
		logic [CODE_W-1:0] code;
		logic valid;
	} acs_result_t;

	// Sample rate in samples per second for each select code
	function automatic int unsigned rate_sps(input logic [RATE_W-1:0] sel);
		case (sel)
			3'h0: rate_sps = 128;
			3'h1: rate_sps = 250;
			3'h2: rate_sps = 490;
			3'h3: rate_sps = 920;
			3'h4: rate_sps = 1600;
			3'h5: rate_sps = 2400;
			default: rate_sps = 3300;
		endcase
	endfunction
endpackage

/* File: logic/acs_decim.sv */
`timescale 1ns/1ps
`default_nettype none
module acs_decim (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic clear_i,
	input wire logic done_i,
	input wire logic sample_en_i,
	input wire logic mod_bit_i,
	output acs_pkg::acs_result_t result_o
);
	import acs_pkg::*;

	typedef struct packed {
		logic signed [ACC_W-1:0] acc;
		logic [ACC_W-1:0] n;
		acs_result_t res;
	} acs_decim_state_t;

	acs_decim_state_t s;
	acs_decim_state_t next_s;
	logic signed [31:0] prod;
	logic signed [31:0] quo;

	always_comb
	begin
		next_s = s;
		next_s.res.valid = 1'b0;
		prod = 32'(s.acc) * 32'(FULL_SCALE);
		quo = 32'sh0000_0000;
		if (s.n != '0)
		begin
			quo = prod / $signed({16'h0000, s.n});
		end
		if (done_i)
		begin
			// Average of the bitstream scaled to full scale
			next_s.res.code = quo[CODE_W-1:0];
			next_s.res.valid = 1'b1;
			next_s.acc = '0;
			next_s.n = '0;
		end
		else if (clear_i)
		begin
			next_s.acc = '0;
			next_s.n = '0;
		end
		else if (sample_en_i)
		begin
			// Each modulator bit weighs plus or minus one
			next_s.acc = mod_bit_i ? s.acc + 16'sh0001 : s.acc - 16'sh0001;
			next_s.n = s.n + 16'h0001;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			s <= '0;
		else
			s <= next_s;
	end

	assign result_o = s.res;
endmodule
`default_nettype wire

/* File: verification/acs_mod_src.sv */
`timescale 1ns/1ps
`default_nettype none
// Stand-in for the modulator: a constant-density bitstream
module acs_mod_src (
	input wire logic clk_i,
	input wire logic level_i,
	output logic mod_bit_o
);
	// Full-scale density only, so filter truncation cannot blur the code
	always_ff @(negedge clk_i)
	begin
		mod_bit_o <= level_i;
	end
endmodule
`default_nettype wire

/* File: verification/acs_sequencer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer_tb;
	import acs_pkg::*;
	// Small clock figure keeps the slowest conversion short
	localparam int unsigned TB_HZ = 2_000_000;
	logic clk_i, sys_rst_i, start_i, mode_i, mod_bit_i, level;
	logic result_valid_o, busy_o, power_down_o;
	logic [RATE_W-1:0] sample_rate_select_i;
	logic [CODE_W-1:0] result_o;
	acs_gc_cmd_t gc;
	int n_errors = 0;
	int comparisons = 0;
	int sps [8] = '{128, 250, 490, 920, 1600, 2400, 3300, 3300};

	acs_sequencer #(.CLK_HZ(TB_HZ)) u_acs_sequencer (.clk_i(clk_i),
		.sys_rst_i(sys_rst_i), .start_i(start_i), .mode_i(mode_i),
		.sample_rate_select_i(sample_rate_select_i), .mod_bit_i(mod_bit_i),
		.gc_cmd_i(gc), .result_o(result_o), .result_valid_o(result_valid_o),
		.busy_o(busy_o), .power_down_o(power_down_o));
	acs_mod_src u_acs_mod_src (.clk_i(clk_i), .level_i(level),
		.mod_bit_o(mod_bit_i));

	task automatic complete_run();
		$display("n_errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			n_errors++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wait_valid(input int lim, output int n);
		n = 0;
		do
		begin
			@(negedge clk_i);
			n++;
		end while (result_valid_o !== 1'b1 && n < lim);
		if (result_valid_o !== 1'b1)
		begin
			n_errors++;
			$display("ERROR t=%0t timeout %h %h", $time, n, lim);
			complete_run();
		end
	endtask

	// Counts result pulses over a stretch; none are expected
	task automatic quiet(input int cycles);
		int hits;
		hits = 0;
		repeat (cycles)
		begin
			@(negedge clk_i);
			hits += (result_valid_o !== 1'b0);
		end
		check(hits, 0);
	endtask

	task automatic kick(input logic [2:0] rate, input logic md);
		sample_rate_select_i = rate;
		mode_i = md;
		start_i = 1'b1;
		@(negedge clk_i);
		start_i = 1'b0;
	endtask

	task automatic single_shot();
		int n;
		level = 1'b1;
		kick(3'h7, 1'b0);
		wait_valid(2000, n);
		check(n, TB_HZ / 3300 + 1);
		check(result_o, 12'h7FF);
		check(power_down_o, 1'b1);
		quiet(700);
	endtask

	task automatic rate_table();
		int n;
		for (int r = 0; r < 8; r++)
		begin
			level = r[0];
			kick(r[2:0], 1'b0);
			wait_valid(20000, n);
			check(n, TB_HZ / sps[r] + 1);
			check(result_o, r[0] ? 12'h7FF : 12'h801);
		end
	endtask

	task automatic continuous();
		int n;
		level = 1'b0;
		kick(3'h5, 1'b1);
		wait_valid(2000, n);
		wait_valid(2000, n);
		check(n, TB_HZ / 2400);
		mode_i = 1'b0;
		repeat (100) @(negedge clk_i);
		start_i = 1'b1;
		@(negedge clk_i);
		start_i = 1'b0;
		check(result_o, 12'h801);
		check(busy_o, 1'b1);
		wait_valid(2000, n);
		check(n, TB_HZ / 2400 - 101);
		quiet(900);
	endtask

	task automatic gc_reset();
		level = 1'b1;
		kick(3'h7, 1'b0);
		repeat (100) @(negedge clk_i);
		gc = '{1'b1, 8'h05};
		@(negedge clk_i);
		check(busy_o, 1'b1);
		gc = '{1'b1, GC_RESET_CODE};
		@(negedge clk_i);
		gc = '0;
		check(busy_o, 1'b0);
		check(power_down_o, 1'b1);
		check(result_o, 12'h000);
		quiet(700);
	endtask

	initial
	begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	initial
	begin
		sys_rst_i = 1'b1;
		start_i = 1'b0;
		mode_i = 1'b0;
		sample_rate_select_i = RATE_RESET;
		gc = '0;
		level = 1'b0;
		repeat (20) @(negedge clk_i);
		sys_rst_i = 1'b0;
		check(result_o, 12'h000);
		check(power_down_o, 1'b1);
		quiet(50);
		single_shot();
		rate_table();
		continuous();
		gc_reset();
		complete_run();
	end
endmodule
`default_nettype wire
